// File: hw/adsq_top.sv
// Summary of operation
// - scan from first channel upward, one conversion each, ending after channel 15
// - first channel code 1111 converts channel 15 only
// - pair code n watches channels n-1 and n; code 0 gives 15 and 0
// - any write to either control register restarts the scan from first channel
// - converter clock period is 2*(divider code+1) system clocks
// - enabled pin trigger starts a sequence on falling edge; disabled ignored
// - enabled timer event starts a sequence; disabled ignored
// - enabled pin and event triggers are ORed; software should enable one
// - accepted trigger sets run bit; single mode clears it at sequence end
// - power bit 0 idles all converter logic; 1 enables converter and analog
// - single mode runs exactly one sequence per trigger or run-bit set
// - repeat mode keeps rerunning sequences after the first start
// - writing run bit 1 starts a sequence, 0 stops conversion
// - pair A high limit split: 9:2 high register, 1:0 at low bits 7:6
// - pair B high limit uses the same split layout
// - scan select resets to first channel 0, pair code 1111
// - converter control resets to divider 101, all other bits clear
// - above flag when result exceeds high limit, below flag under low limit
// - done flag set per sequence; software clears; writing 1 requests interrupt
// - alarm flag set whenever a watched channel crosses a limit
// - each result kept split: 9:2 high byte, 1:0 at low bits 7:6
`timescale 1ns/1ps
`default_nettype none
module adsq_top (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	// axi4-lite write
	input  wire logic [adsq_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read
	input  wire logic [adsq_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// triggers
	input  wire logic                        trigger_input_pin,
	input  wire logic                        timer_event,
	// converter core
	input  wire logic [9:0]                  conv_result,
	input  wire logic [9:0]                  pair_a_low_limit,
	input  wire logic [9:0]                  pair_b_low_limit,
	output logic                             conv_clk,
	output logic                             analog_enable,
	output logic                             sample_active,
	output logic [3:0]                       conv_channel,
	output logic                             soft_irq_req
);
	// ==========================================
	// registers and state
	adsq_pkg::adsq_state_t state_q;
	logic [3:0]  scan_first_channel;
	logic [3:0]  window_channel_pair;
	logic [2:0]  conv_clock_divider;
	logic        pin_trigger_enable;
	logic        event_trigger_enable;
	logic        converter_power_on;
	logic        repeat_sequence_mode;
	logic        run_stop_bit;
	logic [9:0]  pair_a_high_limit;
	logic [9:0]  pair_b_high_limit;
	logic [3:0]  window_result_flags;
	logic        sequence_done_flag;
	logic        window_alarm_flag;
	logic [9:0]  res_q [16];
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  aw_idx_q;
	logic [7:0]  wdata_q;
	logic        wstrb_q;
	logic        restart_q;
	logic        pin_q;
	logic [3:0]  div_q;
	logic [4:0]  tick_cnt_q;
	logic [3:0]  chan_a;
	logic        wr_fire;
	logic        wr_ok;
	logic        ctrl_wr;
	logic        trig_fire;
	logic        tick;
	logic        conv_end;
	logic        seq_end;
	logic [7:0]  ar_idx;
	logic [31:0] rd_d;
	logic        rd_ok;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_ok   = wr_fire && wstrb_q;
	assign ctrl_wr = wr_ok &&
		(aw_idx_q == adsq_pkg::IDX_SCAN_CMP || aw_idx_q == adsq_pkg::IDX_CONV_CTRL);
	assign chan_a  = window_channel_pair - 4'h1;
	assign trig_fire = (pin_trigger_enable && pin_q && !trigger_input_pin) ||
		(event_trigger_enable && timer_event);
	// restart pulse swallows a coinciding conversion end
	assign tick     = (state_q == adsq_pkg::SEQ_CONV) && !restart_q && conv_clk &&
		(div_q == {1'b0, conv_clock_divider});
	assign conv_end = tick && (tick_cnt_q == adsq_pkg::CONV_TICKS - 5'd1);
	assign seq_end  = conv_end && (conv_channel == adsq_pkg::LAST_CHANNEL);
	assign ar_idx   = s_axi_araddr[adsq_pkg::AXI_AW-1:2];

	// ==========================================
	// axi write channel
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_idx_q      <= 8'h00;
			wdata_q       <= 8'h00;
			wstrb_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= adsq_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr[adsq_pkg::AXI_AW-1:2];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata[7:0];
				wstrb_q  <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_idx_q >= adsq_pkg::IDX_A_HI &&
					aw_idx_q <= adsq_pkg::IDX_CONV_CTRL) ||
					aw_idx_q == adsq_pkg::IDX_WIN_RESULT ||
					aw_idx_q == adsq_pkg::IDX_EVENT_FLAGS ?
					adsq_pkg::RESP_OKAY : adsq_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// configuration registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{scan_first_channel, window_channel_pair} <= adsq_pkg::SCAN_CMP_RST;
			conv_clock_divider   <= adsq_pkg::CONV_CTRL_RST[7:adsq_pkg::POS_DIV];
			pin_trigger_enable   <= adsq_pkg::CONV_CTRL_RST[adsq_pkg::POS_PIN_TRG];
			event_trigger_enable <= adsq_pkg::CONV_CTRL_RST[adsq_pkg::POS_EVT_TRG];
			converter_power_on   <= adsq_pkg::CONV_CTRL_RST[adsq_pkg::POS_POWER];
			repeat_sequence_mode <= adsq_pkg::CONV_CTRL_RST[adsq_pkg::POS_REPEAT];
			pair_a_high_limit    <= adsq_pkg::THRESH_RST;
			pair_b_high_limit    <= adsq_pkg::THRESH_RST;
		end
		else if (wr_ok)
		begin
			case (aw_idx_q)
				adsq_pkg::IDX_A_HI: pair_a_high_limit[9:2] <= wdata_q;
				adsq_pkg::IDX_A_LO: pair_a_high_limit[1:0] <= wdata_q[7:6];
				adsq_pkg::IDX_B_HI: pair_b_high_limit[9:2] <= wdata_q;
				adsq_pkg::IDX_B_LO: pair_b_high_limit[1:0] <= wdata_q[7:6];
				adsq_pkg::IDX_SCAN_CMP:
					{scan_first_channel, window_channel_pair} <= wdata_q;
				adsq_pkg::IDX_CONV_CTRL:
				begin
					conv_clock_divider   <= wdata_q[7:adsq_pkg::POS_DIV];
					pin_trigger_enable   <= wdata_q[adsq_pkg::POS_PIN_TRG];
					event_trigger_enable <= wdata_q[adsq_pkg::POS_EVT_TRG];
					converter_power_on   <= wdata_q[adsq_pkg::POS_POWER];
					repeat_sequence_mode <= wdata_q[adsq_pkg::POS_REPEAT];
				end
				default: ;
			endcase
		end
	end

	// ==========================================
	// run bit and restart
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_stop_bit <= adsq_pkg::CONV_CTRL_RST[adsq_pkg::POS_RUN];
			restart_q    <= 1'b0;
			pin_q        <= 1'b1;
		end
		else
		begin
			pin_q     <= trigger_input_pin;
			restart_q <= ctrl_wr;
			// trigger sets run bit, winning over clears
			if (trig_fire)
				run_stop_bit <= 1'b1;
			else if (wr_ok && aw_idx_q == adsq_pkg::IDX_CONV_CTRL)
				run_stop_bit <= wdata_q[adsq_pkg::POS_RUN];
			// single mode ends after one sequence
			else if (seq_end && !repeat_sequence_mode)
				run_stop_bit <= 1'b0;
		end
	end

	// ==========================================
	// sequencer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q       <= adsq_pkg::SEQ_IDLE;
			conv_channel  <= 4'h0;
			div_q         <= 4'h0;
			tick_cnt_q    <= 5'd0;
			conv_clk      <= 1'b0;
			sample_active <= 1'b0;
			analog_enable <= 1'b0;
		end
		else
		begin
			analog_enable <= converter_power_on;
			case (state_q)
				adsq_pkg::SEQ_IDLE:
				begin
					conv_channel  <= scan_first_channel;
					div_q         <= 4'h0;
					tick_cnt_q    <= 5'd0;
					conv_clk      <= 1'b0;
					sample_active <= 1'b0;
					if (converter_power_on && run_stop_bit && !restart_q)
					begin
						state_q       <= adsq_pkg::SEQ_CONV;
						sample_active <= 1'b1;
					end
				end
				adsq_pkg::SEQ_CONV:
				begin
					if (!converter_power_on || !run_stop_bit)
					begin
						state_q       <= adsq_pkg::SEQ_IDLE;
						sample_active <= 1'b0;
						conv_clk      <= 1'b0;
					end
					else if (restart_q)
					begin
						conv_channel  <= scan_first_channel;
						div_q         <= 4'h0;
						tick_cnt_q    <= 5'd0;
						conv_clk      <= 1'b0;
						sample_active <= 1'b1;
					end
					else
					begin
						// half period of divider code + 1 clocks
						if (div_q == {1'b0, conv_clock_divider})
						begin
							div_q    <= 4'h0;
							conv_clk <= !conv_clk;
						end
						else
							div_q <= div_q + 4'h1;
						if (conv_end)
						begin
							tick_cnt_q    <= 5'd0;
							sample_active <= 1'b1;
							if (conv_channel != adsq_pkg::LAST_CHANNEL)
								conv_channel <= conv_channel + 4'h1;
							else
							begin
								// repeat mode reruns from first channel
								conv_channel <= scan_first_channel;
								if (!repeat_sequence_mode && !trig_fire)
								begin
									state_q       <= adsq_pkg::SEQ_IDLE;
									sample_active <= 1'b0;
								end
							end
						end
						else if (tick)
						begin
							tick_cnt_q    <= tick_cnt_q + 5'd1;
							sample_active <= (tick_cnt_q + 5'd1) < adsq_pkg::SAMPLE_TICKS;
						end
					end
				end
				default: state_q <= adsq_pkg::SEQ_IDLE;
			endcase
		end
	end

	// ==========================================
	// result store
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_res
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					res_q[gi] <= 10'h000;
				else if (conv_end && conv_channel == 4'(gi))
					res_q[gi] <= conv_result;
			end
		end
	endgenerate

	// ==========================================
	// window and event flags
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			window_result_flags <= 4'h0;
			sequence_done_flag  <= 1'b0;
			window_alarm_flag   <= 1'b0;
			soft_irq_req        <= 1'b0;
		end
		else
		begin
			soft_irq_req <= 1'b0;
			if (wr_ok && aw_idx_q == adsq_pkg::IDX_WIN_RESULT)
				window_result_flags <= wdata_q[7:4];
			if (wr_ok && aw_idx_q == adsq_pkg::IDX_EVENT_FLAGS)
			begin
				sequence_done_flag <= wdata_q[adsq_pkg::POS_DONE];
				window_alarm_flag  <= wdata_q[adsq_pkg::POS_ALARM];
				soft_irq_req <= wdata_q[adsq_pkg::POS_DONE] ||
					wdata_q[adsq_pkg::POS_ALARM];
			end
			if (conv_end && conv_channel == window_channel_pair)
			begin
				if (conv_result > pair_b_high_limit)
					window_result_flags[3] <= 1'b1;
				if (conv_result < pair_b_low_limit)
					window_result_flags[1] <= 1'b1;
				if (conv_result > pair_b_high_limit || conv_result < pair_b_low_limit)
					window_alarm_flag <= 1'b1;
			end
			if (conv_end && conv_channel == chan_a)
			begin
				if (conv_result > pair_a_high_limit)
					window_result_flags[2] <= 1'b1;
				if (conv_result < pair_a_low_limit)
					window_result_flags[0] <= 1'b1;
				if (conv_result > pair_a_high_limit || conv_result < pair_a_low_limit)
					window_alarm_flag <= 1'b1;
			end
			if (seq_end)
				sequence_done_flag <= 1'b1;
		end
	end

	// ==========================================
	// axi read channel
	always_comb
	begin
		rd_d  = 32'h0000_0000;
		rd_ok = 1'b1;
		case (ar_idx)
			adsq_pkg::IDX_A_HI:      rd_d[7:0] = pair_a_high_limit[9:2];
			adsq_pkg::IDX_A_LO:      rd_d[7:0] = {pair_a_high_limit[1:0], 6'h00};
			adsq_pkg::IDX_B_HI:      rd_d[7:0] = pair_b_high_limit[9:2];
			adsq_pkg::IDX_B_LO:      rd_d[7:0] = {pair_b_high_limit[1:0], 6'h00};
			adsq_pkg::IDX_SCAN_CMP:  rd_d[7:0] = {scan_first_channel, window_channel_pair};
			adsq_pkg::IDX_CONV_CTRL: rd_d[7:0] = {conv_clock_divider, pin_trigger_enable,
				event_trigger_enable, converter_power_on, repeat_sequence_mode, run_stop_bit};
			adsq_pkg::IDX_WIN_RESULT:  rd_d[7:0] = {window_result_flags, 4'h0};
			adsq_pkg::IDX_EVENT_FLAGS: rd_d[7:0] = {sequence_done_flag, window_alarm_flag, 6'h00};
			default:
			begin
				if (ar_idx[7:4] == adsq_pkg::IDX_RESULT_BASE[7:4])
					rd_d[15:0] = {res_q[ar_idx[3:0]], 6'h00};
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= adsq_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= rd_ok ? adsq_pkg::RESP_OKAY : adsq_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================
	// checks
	logic [3:0] hi_len_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hi_len_q <= 4'h0;
		else if (!conv_clk)
			hi_len_q <= 4'h0;
		else
			hi_len_q <= hi_len_q + 4'h1;
	end

	a_restart_channel: assert property (@(posedge sys_clk) disable iff (!rst_n)
		restart_q && state_q == adsq_pkg::SEQ_CONV && run_stop_bit && converter_power_on
		|=> conv_channel == $past(scan_first_channel))
		else $error("restart did not reload first channel");
	a_scan_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_end && !restart_q && run_stop_bit && converter_power_on &&
		conv_channel != adsq_pkg::LAST_CHANNEL |=> conv_channel == $past(conv_channel) + 4'h1)
		else $error("scan channel did not advance by one");
	a_divider_half: assert property (@(posedge sys_clk) disable iff (!rst_n || restart_q)
		$fell(conv_clk) && $past(state_q) == adsq_pkg::SEQ_CONV && !$past(restart_q) &&
		$past(run_stop_bit) && $past(converter_power_on)
		|-> hi_len_q == {1'b0, $past(conv_clock_divider)} + 4'h1)
		else $error("converter clock high phase wrong length");
	a_pin_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pin_trigger_enable && pin_q && !trigger_input_pin |=> run_stop_bit)
		else $error("pin trigger did not set run bit");
	a_event_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		event_trigger_enable && timer_event |=> run_stop_bit)
		else $error("event trigger did not set run bit");
	a_trigger_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!run_stop_bit && !pin_trigger_enable && !event_trigger_enable && !wr_ok
		|=> !run_stop_bit)
		else $error("run bit set with triggers disabled");
	a_single_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seq_end && !repeat_sequence_mode && !trig_fire && !wr_ok
		|=> !run_stop_bit ##1 state_q == adsq_pkg::SEQ_IDLE)
		else $error("single mode did not stop after sequence");
	a_power_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!converter_power_on |=> !analog_enable && state_q == adsq_pkg::SEQ_IDLE && !sample_active)
		else $error("converter active while powered down");
	a_upper_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_end && conv_channel == chan_a && conv_result > pair_a_high_limit
		|=> window_result_flags[2] && window_alarm_flag)
		else $error("pair a above flag not set");
	a_done_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seq_end |=> sequence_done_flag)
		else $error("done flag not set at sequence end");
endmodule
`default_nettype wire

// File: hw/adsq_pkg.sv
package adsq_pkg;
	// ==========================================
	// register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_RESULT_BASE   = 8'h00;
	localparam logic [7:0] IDX_A_HI          = 8'hf8;
	localparam logic [7:0] IDX_A_LO          = 8'hf9;
	localparam logic [7:0] IDX_B_HI          = 8'hfa;
	localparam logic [7:0] IDX_B_LO          = 8'hfb;
	localparam logic [7:0] IDX_SCAN_CMP      = 8'hfc;
	localparam logic [7:0] IDX_CONV_CTRL     = 8'hfd;
	localparam logic [7:0] IDX_WIN_RESULT    = 8'hf0;
	localparam logic [7:0] IDX_EVENT_FLAGS   = 8'hf1;
	localparam int         AXI_AW            = 10;
	// ==========================================
	// reset values
	localparam logic [7:0] SCAN_CMP_RST      = 8'h0f;
	localparam logic [7:0] CONV_CTRL_RST     = 8'ha0;
	localparam logic [9:0] THRESH_RST        = 10'h000;
	// ==========================================
	// field positions in the converter control and event flag bytes
	localparam int         POS_DIV           = 5;
	localparam int         POS_PIN_TRG       = 4;
	localparam int         POS_EVT_TRG       = 3;
	localparam int         POS_POWER         = 2;
	localparam int         POS_REPEAT        = 1;
	localparam int         POS_RUN           = 0;
	localparam int         POS_DONE          = 7;
	localparam int         POS_ALARM         = 6;
	// ==========================================
	// timing, in converter clock periods
	localparam logic [4:0] SAMPLE_TICKS      = 5'd8;
	localparam logic [4:0] CONV_TICKS        = 5'd28;
	localparam logic [3:0] LAST_CHANNEL      = 4'hf;
	// ==========================================
	// bus answers
	localparam logic [1:0] RESP_OKAY         = 2'b00;
	localparam logic [1:0] RESP_SLVERR       = 2'b10;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_CONV = 2'b10
	} adsq_state_t;
endpackage

// File: testbench/adsq_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// converter core and trigger source
module adsq_far_model (
	// clock and block status
	input  wire logic       sys_clk,
	input  wire logic [3:0] conv_channel,
	input  wire logic       sample_active,
	// bench command
	input  wire logic       pin_fire,
	// to the block
	output logic [9:0]      conv_result,
	output logic            trigger_input_pin,
	output logic [9:0]      pair_a_low_limit,
	output logic [9:0]      pair_b_low_limit
);
	logic       sa_q  = 1'h0;
	logic [1:0] low_n = 2'h0;
	logic [9:0] res_q = 10'h000;
	assign conv_result = res_q;
	assign pair_a_low_limit = 10'h3e0;
	assign pair_b_low_limit = 10'h3ff;
	assign trigger_input_pin = (low_n == 2'h0);
	// value held once sampling starts
	always @(posedge sys_clk)
	begin
		sa_q <= sample_active;
		if (sample_active && !sa_q)
			res_q <= {conv_channel, 6'h15};
		if (pin_fire)
			low_n <= 2'h3;
		else if (low_n != 2'h0)
			low_n <= low_n - 2'h1;
	end
endmodule
`default_nettype wire

// File: testbench/adsq_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module adsq_top_test;
	localparam logic [1:0] OK = adsq_pkg::RESP_OKAY;
	localparam logic [1:0] ER = adsq_pkg::RESP_SLVERR;
	localparam logic [7:0] SEL = adsq_pkg::IDX_SCAN_CMP;
	localparam logic [7:0] CT = adsq_pkg::IDX_CONV_CTRL;
	localparam logic [7:0] WF = adsq_pkg::IDX_WIN_RESULT;
	localparam logic [7:0] EF = adsq_pkg::IDX_EVENT_FLAGS;
	localparam logic [7:0] AH = adsq_pkg::IDX_A_HI;
	logic [adsq_pkg::AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]                 s_axi_wdata, s_axi_rdata, rv;
	logic [31:0]                 rs = 32'h8d2401de;
	logic [9:0]                  conv_result, pair_a_low_limit, pair_b_low_limit;
	logic [3:0]                  s_axi_wstrb = 4'hf;
	logic [3:0]                  conv_channel;
	logic [3:0]                  chq [$];
	logic [1:0]                  s_axi_bresp, s_axi_rresp, lr, lb;
	logic                        sys_clk = 1'h0;
	logic                        rst_n = 1'h0;
	logic                        s_axi_bready = 1'h1;
	logic                        s_axi_rready = 1'h1;
	logic                        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, timer_event;
	logic                        pin_fire, sa_q, cc_q, trigger_input_pin, soft_irq_req;
	logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                        s_axi_rvalid, conv_clk, analog_enable, sample_active;
	int                          fails = 0;
	int                          n_compared = 0;
	int                          cyc = 0;
	int                          irqs = 0;
	int                          per, sl, cnt, k;
	adsq_top dut (
		.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_input_pin,
		.timer_event, .conv_result, .pair_a_low_limit, .pair_b_low_limit, .conv_clk,
		.analog_enable, .sample_active, .conv_channel, .soft_irq_req
	);
	adsq_far_model far (
		.sys_clk, .conv_channel, .sample_active, .pin_fire, .conv_result,
		.trigger_input_pin, .pair_a_low_limit, .pair_b_low_limit
	);
	always #2.5 sys_clk = ~sys_clk;
	// ==========================================
	// monitors and hang guard
	always @(posedge sys_clk)
	begin
		sa_q <= sample_active;
		cc_q <= conv_clk;
		cyc <= cyc + 1;
		cnt <= (conv_clk && !cc_q) ? 1 : cnt + 1;
		if (conv_clk && !cc_q)
			per <= cnt;
		sl <= (sample_active && !sa_q) ? 1 : sl + int'(sample_active);
		if (sample_active && !sa_q)
			chq.push_back(conv_channel);
		if (soft_irq_req)
			irqs <= irqs + 1;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	// ==========================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic aw, w;
		{aw, w} = 2'h0;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		while (!(aw && w))
		begin
			@(posedge sys_clk);
			aw |= s_axi_awvalid & s_axi_awready;
			w |= s_axi_wvalid & s_axi_wready;
			s_axi_awvalid <= s_axi_awvalid & !s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid & !s_axi_wready;
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
		lb = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] idx);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		lr = s_axi_rresp;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		rd(idx);
		chk(rv, {24'h000000, exp});
		chk(lr, OK);
	endtask
	task automatic lim(input logic [9:0] a, input logic [9:0] b);
		wr(AH, a[9:2]);
		wr(AH + 8'h1, {a[1:0], 6'h00});
		wr(AH + 8'h2, b[9:2]);
		wr(AH + 8'h3, {b[1:0], 6'h00});
	endtask
	task automatic wait_idle;
		repeat (10) @(posedge sys_clk);
		do rd(CT); while (rv[0]);
	endtask
	task automatic go(input logic [7:0] s, input logic [7:0] c);
		wr(SEL, s);
		chq.delete();
		wr(CT, c);
		wait_idle();
	endtask
	task automatic chk_seq(input logic [3:0] f);
		logic [3:0] e [$];
		for (int c = f; c < 16; c++)
			e.push_back(4'(c));
		chk(chq.size(), e.size());
		foreach (e[i])
			chk(chq[i], e[i]);
	endtask
	// one-cycle timer pulse or three-cycle low pin pulse, returning after one clock
	task automatic fire(input int src);
		pin_fire <= (src == 0);
		timer_event <= (src == 1);
		@(posedge sys_clk);
		{pin_fire, timer_event} <= 2'h0;
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, timer_event, pin_fire} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rdc(SEL, 8'h0f);
		rdc(CT, 8'ha0);
		rd(8'h80);
		chk(lr, ER);
		wr(8'h80, 8'h5a);
		chk(lb, ER);
		repeat (4)
		begin
			rs = xs(rs);
			for (k = 0; k < 2; k++)
			begin
				wr(AH + 8'(2 * k), rs[16 * k +: 8]);
				wr(AH + 8'(2 * k + 1), rs[16 * k + 8 +: 8]);
				chk(lb, OK);
				rdc(AH + 8'(2 * k), rs[16 * k +: 8]);
				rdc(AH + 8'(2 * k + 1), {rs[16 * k + 14 +: 2], 6'h00});
			end
		end
		lim(10'h3ff, 10'h000);
		go(8'hef, 8'h05);
		chk_seq(4'he);
		rdc(WF, 8'hb0);
		rdc(EF, 8'hc0);
		rdc(CT, 8'h04);
		wr(EF, 8'h00);
		wr(EF, 8'h80);
		repeat (2) @(posedge sys_clk);
		chk(irqs, 1);
		wr(EF, 8'h00);
		wr(WF, 8'h00);
		lim(10'h000, 10'h000);
		go(8'hf0, 8'h05);
		chk_seq(4'hf);
		rdc(WF, 8'h50);
		for (k = 0; k < 8; k++)
		begin
			go(8'hf0, {3'(k), 5'h05});
			chk(per, 2 * (k + 1));
			chk(sl, 16 * (k + 1));
			chk(analog_enable, 1'h1);
		end
		wr(SEL, 8'hcf);
		chq.delete();
		wr(CT, 8'h05);
		repeat (80) @(posedge sys_clk);
		wr(SEL, 8'hcf);
		wait_idle();
		chk(chq.size(), 6);
		chk(chq[2], 4'hc);
		wr(SEL, 8'hf0);
		chq.delete();
		wr(CT, 8'h01);
		repeat (100) @(posedge sys_clk);
		chk(chq.size(), 0);
		chk(analog_enable, 1'h0);
		wr(CT, 8'h00);
		for (k = 0; k < 2; k++)
		begin
			wr(CT, 8'h04);
			fire(k);
			repeat (20) @(posedge sys_clk);
			rdc(CT, 8'h04);
			chq.delete();
			wr(CT, k ? 8'h0c : 8'h14);
			fire(k);
			repeat (10) @(posedge sys_clk);
			rdc(CT, k ? 8'h0d : 8'h15);
			wait_idle();
			chk_seq(4'hf);
		end
		chq.delete();
		wr(CT, 8'h07);
		while (chq.size() < 3)
			@(posedge sys_clk);
		wr(CT, 8'h04);
		repeat (10) @(posedge sys_clk);
		k = chq.size();
		repeat (200) @(posedge sys_clk);
		chk(chq.size(), k);
		chk(chq[2], 4'hf);
		rdc(CT, 8'h04);
		tally_and_finish();
	end
endmodule
`default_nettype wire
